/* logic/asr_defines.svh */
// Purpose: timing constants for the async static memory host port
// Assumes: core clock of 125 MHz (8 ns period)
// Notes:   ns times round up to whole cycles, power-up count rounds down
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH
`define ASR_CLK_PS            8000
`define ASR_ADDR_W            15
`define ASR_DATA_W            8
`define ASR_CYCLE_NS          25
`define ASR_ACCESS_NS         25
`define ASR_DOE_NS            11
`define ASR_STROBE_NS         18
`define ASR_SETUP_NS          12
`define ASR_HOLD_NS           0
`define ASR_FLOAT_NS          11
`define ASR_POWERUP_US        100
`define ASR_CYC_UP(ns)        (((ns) * 1000 + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
`define ASR_POWERUP_CYC       ((`ASR_POWERUP_US * 1000000) / `ASR_CLK_PS)
`endif

/* logic/asr_host.sv */
// Purpose: host controller driving a 32K x 8 async static memory
// Assumes: memory pins are external; data input passes two flip-flops
// Notes:   one access at a time; req_ready high only in idle
//
// Summary of operation
// [R01] Write only while select and strobe low
// [R02] Write ends when select or strobe rises
// [R03] Data timed from write-ending rising edge
// [R04] Data setup 12 ns, hold 0 ns
// [R05] Address stable, strobe 18 ns, cycle 25
// [R06] Strobe low covers setup plus float delay
// [R07] Select and strobe rise together: data floats
// [R08] Host never drives while memory drives
// [R09] Read data 25 ns after address, cycle 25
// [R10] Read data 25 ns after select falls
// [R11] Read data 11 ns after drive falls
// [R12] Wait 100 us before first access
// [R13] Standby within 25 ns of deselect
// [R14] Memory floats faster than it turns on
// [R15] Memory floats unless selected reading
// [R16] Select and strobe low store the data
// [R17] 32768 locations of 8 bits
// [R18] Read returns last written value
`timescale 1ns/1ps
`include "asr_defines.svh"
module asr_host #(
   parameter int ADDR_W      = `ASR_ADDR_W,
   parameter int DATA_W      = `ASR_DATA_W,
   parameter int POWERUP_CYC = `ASR_POWERUP_CYC
) (
   input  wire logic              core_clk,
   input  wire logic              srst,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_rdata,
   output logic                   init_done,
   output logic [ADDR_W-1:0]      mem_addr,
   output logic                   mem_sel_n,
   output logic                   mem_wstb_n,
   output logic                   mem_drv_n,
   input  wire logic [DATA_W-1:0] mem_data_in,
   output logic [DATA_W-1:0]      mem_data_out,
   output logic                   mem_data_oe_n
);
   import asr_pkg::*;

   localparam int TW = 24;
   // Read: access plus two sync stages so the sampled byte is settled
   localparam int RD_CYC  = `ASR_CYC_UP(`ASR_ACCESS_NS) + 2;
   localparam int WR_CYC  = `ASR_CYC_UP(`ASR_STROBE_NS);
   localparam int SU_CYC  = `ASR_CYC_UP(`ASR_SETUP_NS + `ASR_FLOAT_NS);
   localparam int LOW_CYC = (WR_CYC > SU_CYC) ? WR_CYC : SU_CYC;
   localparam int REC_CYC = `ASR_CYC_UP(`ASR_FLOAT_NS);

   initial begin
      if (ADDR_W != `ASR_ADDR_W || DATA_W != `ASR_DATA_W)
         $error("memory is 32768 x 8 only");
      if (POWERUP_CYC < 1 || POWERUP_CYC >= (1 << TW))
         $error("power-up count out of range");
   end

   asr_state_t state;
   asr_state_t next_state;
   logic            tmr_load;
   logic [TW-1:0]   tmr_val;
   logic            tmr_done;
   logic [DATA_W-1:0] din_s1;
   logic [DATA_W-1:0] din_s2;
   logic            boot_load;

   asr_timer #(.W(TW)) u_timer (
      .core_clk (core_clk),
      .srst     (srst),
      .load     (tmr_load),
      .load_val (tmr_val),
      .done     (tmr_done)
   );

   // Two-stage sampling of the memory data pins
   always_ff @(posedge core_clk) begin
      din_s1 <= mem_data_in;
      din_s2 <= din_s1;
   end

   always_comb begin
      next_state = state;
      tmr_load   = 1'b0;
      tmr_val    = '0;
      case (state)
         ASR_WAIT: begin
            // [R12] power-up count loaded once
            // Timer is still zero here, so done must not end the wait
            if (boot_load) begin
               tmr_load = 1'b1;
               tmr_val  = TW'(POWERUP_CYC - 1);
            end else if (tmr_done) begin
               next_state = ASR_IDLE;
            end
         end
         ASR_IDLE: begin
            if (req_valid) begin
               tmr_load = 1'b1;
               if (req_write) begin
                  // [R06] strobe width rule
                  next_state = ASR_WRLOW;
                  tmr_val    = TW'(LOW_CYC - 1);
               end else begin
                  next_state = ASR_RDACC;
                  tmr_val    = TW'(RD_CYC - 1);
               end
            end
         end
         ASR_RDACC: begin
            if (tmr_done) begin
               next_state = ASR_REC;
               tmr_load   = 1'b1;
               tmr_val    = TW'(REC_CYC - 1);
            end
         end
         ASR_WRLOW: begin
            if (tmr_done) next_state = ASR_WRHLD;
         end
         ASR_WRHLD: begin
            // [R08] float gap before next owner
            next_state = ASR_REC;
            tmr_load   = 1'b1;
            tmr_val    = TW'(REC_CYC - 1);
         end
         ASR_REC: begin
            if (tmr_done) next_state = ASR_IDLE;
         end
         default: next_state = ASR_IDLE;
      endcase
   end

   // [R12] power-up wait
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= ASR_WAIT;
      end else begin
         state <= next_state;
      end
   end

   // Power-up count loaded by the timer through a reset-time load
   always_ff @(posedge core_clk) begin
      if (srst) begin
         boot_load <= 1'b1;
      end else begin
         boot_load <= 1'b0;
      end
   end

   assign req_ready = (state == ASR_IDLE);
   assign init_done = (state != ASR_WAIT);

   // [R05] address held through access
   always_ff @(posedge core_clk) begin
      if (srst) begin
         mem_addr <= '0;
      end else if (state == ASR_IDLE && req_valid) begin
         mem_addr <= req_addr;
      end
   end

   // [R01] select and strobe low together
   always_ff @(posedge core_clk) begin
      if (srst) begin
         mem_sel_n  <= 1'b1;
         mem_wstb_n <= 1'b1;
         mem_drv_n  <= 1'b1;
      end else begin
         // [R13] deselect between accesses
         mem_sel_n  <= !(next_state == ASR_RDACC ||
                         next_state == ASR_WRLOW);
         // [R02] strobe rise ends the write
         mem_wstb_n <= !(next_state == ASR_WRLOW);
         // [R11] drive only during reads
         mem_drv_n  <= !(next_state == ASR_RDACC);
      end
   end

   // [R04] data set up before, held after
   always_ff @(posedge core_clk) begin
      if (srst) begin
         mem_data_out  <= '0;
         mem_data_oe_n <= 1'b1;
      end else begin
         if (state == ASR_IDLE && req_valid && req_write) begin
            mem_data_out <= req_wdata;
         end
         // [R03] hold past strobe rise
         mem_data_oe_n <= !(next_state == ASR_WRLOW ||
                            next_state == ASR_WRHLD);
      end
   end

   // [R09] sample after access time
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         rsp_valid <= 1'b0;
         if (state == ASR_RDACC && tmr_done) begin
            rsp_valid <= 1'b1;
            rsp_rdata <= din_s2;
         end else if (state == ASR_WRHLD) begin
            rsp_valid <= 1'b1;
         end
      end
   end
endmodule

/* logic/asr_pkg.sv */
// Purpose: types for the async static memory host port
// Assumes: nothing
// Notes:   one-hot state codes
package asr_pkg;
   typedef enum logic [5:0] {
      ASR_WAIT  = 6'h01,
      ASR_IDLE  = 6'h02,
      ASR_RDACC = 6'h04,
      ASR_WRLOW = 6'h08,
      ASR_WRHLD = 6'h10,
      ASR_REC   = 6'h20
   } asr_state_t;
endpackage

/* logic/asr_timer.sv */
// Purpose: down counter timing each phase of a memory cycle
// Assumes: load and count on the same clock
// Notes:   done is high while the count is zero
`timescale 1ns/1ps
module asr_timer #(
   parameter int W = 14
) (
   input  wire logic         core_clk,
   input  wire logic         srst,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   output logic              done
);
   logic [W-1:0] count;

   initial begin
      if (W < 2) $error("timer width too small");
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         count <= '0;
      end else if (load) begin
         count <= load_val;
      end else if (count != '0) begin
         count <= count - 1'b1;
      end
   end

   assign done = (count == '0);
endmodule

/* tb/asr_host_sva.sv */
// Purpose: pin timing checks for the memory host
// Assumes: 8 ns clock
// Notes:   cycle counts follow the hand-over walk
`timescale 1ns/1ps
module asr_host_sva (
   input wire logic        core_clk,
   input wire logic        srst,
   input wire logic        rsp_valid,
   input wire logic        init_done,
   input wire logic [14:0] mem_addr,
   input wire logic        mem_sel_n,
   input wire logic        mem_wstb_n,
   input wire logic        mem_drv_n,
   input wire logic [7:0]  mem_data_out,
   input wire logic        mem_data_oe_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   wr_gate_a: assert property (
      !mem_wstb_n |-> !mem_sel_n) else $error("strobe alone");
   no_clash_a: assert property (
      !mem_drv_n |-> mem_data_oe_n) else $error("bus clash");
   strobe_len_a: assert property (
      $fell(mem_wstb_n) |-> !mem_wstb_n[*3] ##1 mem_wstb_n)
      else $error("strobe length");
   wdata_hold_a: assert property (
      !mem_wstb_n |=> $stable(mem_data_out) && !mem_data_oe_n)
      else $error("write data moved");
   addr_hold_a: assert property (
      !mem_sel_n |=> $stable(mem_addr)) else $error("address moved");
   rd_window_a: assert property (
      $fell(mem_drv_n) |-> (!mem_drv_n && !mem_sel_n)[*6]
      ##1 (mem_drv_n && rsp_valid)) else $error("read window");
   sel_gap_a: assert property (
      $rose(mem_sel_n) |-> mem_sel_n[*3]) else $error("cycle gap");
   rsp_pulse_a: assert property (
      rsp_valid |=> !rsp_valid) else $error("response stuck");
   boot_quiet_a: assert property (
      !init_done |-> mem_sel_n) else $error("access before power-up");
endmodule
bind asr_host asr_host_sva u_sva (.core_clk, .srst, .rsp_valid, .init_done,
   .mem_addr, .mem_sel_n, .mem_wstb_n, .mem_drv_n, .mem_data_out,
   .mem_data_oe_n);

/* tb/asr_host_test.sv */
// Purpose: self-checking bench for the memory host
// Assumes: behavioural memory on the pins
// Notes:   short power-up count keeps the run brief
`timescale 1ns/1ps
module asr_host_test;
   logic        core_clk = 1'b0;
   logic        srst = 1'b1;
   logic        req_valid = 1'b0;
   logic        req_write = 1'b0;
   logic [14:0] req_addr = 15'h0000;
   logic [7:0]  req_wdata = 8'h00;
   logic        req_ready, rsp_valid, init_done, mem_sel_n;
   logic        mem_wstb_n, mem_drv_n, mem_data_oe_n;
   logic [14:0] mem_addr;
   logic [7:0]  rsp_rdata, mem_data_in, mem_data_out, q;
   int          err_total = 0;
   int          comparisons = 0;
   localparam int PWR = 4;

   asr_host #(.POWERUP_CYC(PWR)) u_asr_host (.core_clk, .srst,
      .req_valid, .req_ready, .req_write, .req_addr, .req_wdata,
      .rsp_valid, .rsp_rdata, .init_done, .mem_addr, .mem_sel_n,
      .mem_wstb_n, .mem_drv_n, .mem_data_in, .mem_data_out,
      .mem_data_oe_n);
   asr_mem_model u_asr_mem_model (.mem_addr, .mem_sel_n, .mem_wstb_n,
      .mem_drv_n, .mem_data_out, .mem_data_oe_n, .mem_data_in);

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (err_total == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Entered at a falling edge; waits are bounded so a hang is reported
   task automatic access(input logic w, input logic [14:0] a,
                         input logic [7:0] d);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      req_valid = 1'b1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      @(negedge core_clk);
      req_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      q = rsp_rdata;
      check({7'h00, rsp_valid}, 8'h01);
   endtask

   // Entered at the release of reset; the wait must last the whole count
   task automatic t_init();
      int n;
      n = 0;
      while (init_done !== 1'b1 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      check({7'h00, init_done}, 8'h01);
      check(8'(n >= PWR), 8'h01);
      check({4'h0, mem_sel_n, mem_wstb_n, mem_drv_n, mem_data_oe_n},
            8'h0f);
   endtask

   // Every address line alone plus the top location, so aliasing shows
   task automatic t_walk();
      for (int i = 0; i < 16; i++)
         access(1'b1, i == 15 ? 15'h7fff : 15'h0001 << i, 8'(i + 8'h31));
      for (int i = 0; i < 16; i++) begin
         access(1'b0, i == 15 ? 15'h7fff : 15'h0001 << i, 8'h00);
         check(q, 8'(i + 8'h31));
      end
   endtask

   task automatic t_over();
      access(1'b1, 15'h1234, 8'h0f);
      access(1'b1, 15'h1234, 8'hf0);
      access(1'b0, 15'h1234, 8'h00);
      check(q, 8'hf0);
      access(1'b0, 15'h1234, 8'h00);
      check(q, 8'hf0);
   endtask

   initial forever #4 core_clk = ~core_clk;

   initial begin
      repeat (12) @(negedge core_clk);
      srst = 1'b0;
      t_init();
      t_walk();
      t_over();
      tally_and_finish();
   end

   initial begin
      #100000;
      err_total++;
      tally_and_finish();
   end
endmodule

/* tb/asr_mem_model.sv */
// Purpose: behavioural 32K x 8 static memory on the host pins
// Assumes: pins of asr_host
// Notes:   a floating bus shows the inverse of its last value
`timescale 1ns/1ps
module asr_mem_model #(
   parameter int DLY = 25
) (
   input  wire logic [14:0] mem_addr,
   input  wire logic        mem_sel_n,
   input  wire logic        mem_wstb_n,
   input  wire logic        mem_drv_n,
   input  wire logic [7:0]  mem_data_out,
   input  wire logic        mem_data_oe_n,
   output logic [7:0]       mem_data_in
);
   logic [7:0] ram [0:32767];
   logic [7:0] rd;
   logic [7:0] last = 8'h00;
   wire mdrv = !mem_sel_n && mem_wstb_n && !mem_drv_n;
   assign #DLY rd = ram[mem_addr];
   assign mem_data_in = !mem_data_oe_n ? mem_data_out : mdrv ? rd : ~last;
   always @(mem_data_in)
      if (!mem_data_oe_n || mdrv) last = mem_data_in;
   always @(mem_sel_n, mem_wstb_n, mem_addr, mem_data_in)
      if (!mem_sel_n && !mem_wstb_n) ram[mem_addr] = mem_data_in;
endmodule
